// *** design/dual_uart_defines.vh ***
// Constants shared by the dual serial unit design files
`ifndef DUAL_UART_DEFINES_VH
`define DUAL_UART_DEFINES_VH
// Register offsets
`define OFS_DATA      3'h0
`define OFS_IER       3'h1
`define OFS_IIR       3'h2
`define OFS_FMT       3'h3
`define OFS_HSO       3'h4
`define OFS_LINK      3'h5
`define OFS_HSI       3'h6
`define OFS_SCRATCH   3'h7
// Frame format fields
`define FMT_LEN_LO    0
`define FMT_LEN_HI    1
`define FMT_STOP      2
`define FMT_PAR_EN    3
`define FMT_EVEN      4
`define FMT_STICK     5
`define FMT_BREAK     6
`define FMT_DIV_SEL   7
// Reset values
`define RST_BYTE      8'h00
`define RST_DIV       16'h0001
`define RST_DIV_LO    8'h01
`define MODE_ARM      3'h7
`define RST_IIR       8'h01
`define RST_HSO       8'h00
// Timing in sixteenth-bit ticks
`define TICKS_BIT     5'h10
`define TICKS_HALF    5'h08
`define TICKS_ONEHALF 5'h18
`define TICKS_TWO     6'h20
// Receiver sub-tick preset: start sample lands near mid-bit
`define RX_SUB_START  4'h9
`define TICK_MAX      4'hF
`define LEN_BASE      4'h5
`endif

// *** design/baud_tick_gen.v ***
// Baud divider producing the sixteen-times bit-rate tick
`include "dual_uart_defines.vh"
module baud_tick_gen (
	input  wire        core_clk,
	input  wire        reset,
	input  wire [15:0] divisor,
	input  wire        reload,
	output reg         tick
);
	reg [15:0] count_q;

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count_q <= `RST_DIV;
			tick    <= 1'b0;
		end else if (reload) begin
			count_q <= divisor;
			tick    <= 1'b0;
		end else if (count_q <= 16'h0001) begin
			count_q <= divisor; // Divisor of zero behaves as one
			tick    <= 1'b1;
		end else begin
			count_q <= count_q - 16'h0001;
			tick    <= 1'b0;
		end
	end
endmodule // baud_tick_gen

// *** design/serial_channel.v ***
// One complete serial channel: registers, transmitter and receiver
`include "dual_uart_defines.vh"
module serial_channel (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       ext_mode,
	input  wire       sel,
	input  wire [2:0] addr,
	input  wire       rd_stb,
	input  wire       wr_stb,
	input  wire [7:0] wdata,
	output reg  [7:0] rdata,
	input  wire       serial_in,
	output wire       serial_output_pin
);
	reg  [7:0] fmt_q, ier_q, hso_q, scr_q, tcr_q, div_lo_q, div_hi_q;
	reg  [7:0] thr_q, rbr_q;
	reg        tx_holding_empty_flag_q, dr_q, oe_q, pe_q, fe_q, bi_q;
	wire       tick;
	wire       wr = sel & wr_stb;
	wire       rd = sel & rd_stb;
	wire       dsel = fmt_q[`FMT_DIV_SEL];
	wire [3:0] nbits = `LEN_BASE + {2'b00, fmt_q[`FMT_LEN_HI:`FMT_LEN_LO]};
	wire       reload = wr & dsel & (addr == `OFS_DATA || addr == `OFS_IER);

	// Per-channel baud generator
	baud_tick_gen u_baud (
		.core_clk (core_clk),
		.reset    (reset),
		.divisor  ({div_hi_q, div_lo_q}),
		.reload   (reload),
		.tick     (tick)
	);

	// Parity bit: stick, even or odd
	function par_of;
		input [7:0] d;
		input [3:0] n;
		input [7:0] f;
		reg         x;
		begin
			x = ^(d & ((8'h01 << n) - 8'h01));
			if (f[`FMT_STICK])
				par_of = ~f[`FMT_EVEN];
			else
				par_of = f[`FMT_EVEN] ? x : ~x;
		end
	endfunction

	// Transmitter
	localparam TX_IDLE = 4'b0001, TX_START = 4'b0010;
	localparam TX_DATA = 4'b0100, TX_STOP  = 4'b1000;
	reg [3:0] tx_st_q;
	reg [7:0] tx_sh_q;
	reg [3:0] tx_cnt_q, tx_sub_q;
	reg       tx_par_q, tx_line_q, tx_pdone_q;
	reg [5:0] stop_len;
	always @* begin
		// stop length by format
		// Six bits: two full stops do not fit in five
		if (!fmt_q[`FMT_STOP])
			stop_len = {1'b0, `TICKS_BIT};
		else if (fmt_q[`FMT_LEN_HI:`FMT_LEN_LO] == 2'b00)
			stop_len = {1'b0, `TICKS_ONEHALF};
		else
			stop_len = `TICKS_TWO;
	end
	reg [5:0] stop_cnt_q;
	wire      tx_bit_end = tick & (tx_sub_q == `TICK_MAX);
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= `RST_BYTE;
			tx_cnt_q <= 4'h0;
			tx_sub_q <= 4'h0;
			tx_par_q <= 1'b0;
			tx_pdone_q <= 1'b0;
			stop_cnt_q <= 6'h00;
			tx_line_q <= 1'b1;
		end else begin
			if (tick)
				tx_sub_q <= tx_sub_q + 4'h1;
			case (tx_st_q)
			TX_IDLE: begin
				tx_line_q <= 1'b1;
				if (!tx_holding_empty_flag_q && tick) begin
					tx_sh_q <= thr_q;
					tx_par_q <= par_of(thr_q, nbits, fmt_q);
					tx_sub_q <= 4'h0; // Full sixteen ticks of start
					tx_cnt_q <= 4'h0;
					tx_pdone_q <= 1'b0;
					tx_line_q <= 1'b0;
					tx_st_q <= TX_START;
				end
			end
			TX_START: if (tx_bit_end) begin
				tx_st_q <= TX_DATA;
				tx_line_q <= tx_sh_q[0];
			end
			TX_DATA: if (tx_bit_end) begin
				if (tx_cnt_q + 4'h1 < nbits) begin
					tx_cnt_q <= tx_cnt_q + 4'h1;
					tx_sh_q <= {1'b0, tx_sh_q[7:1]};
					tx_line_q <= tx_sh_q[1];
				end else if (fmt_q[`FMT_PAR_EN] && !tx_pdone_q) begin
					tx_pdone_q <= 1'b1;
					tx_line_q <= tx_par_q;
				end else begin
					tx_line_q <= 1'b1;
					stop_cnt_q <= 6'h01;
					tx_st_q <= TX_STOP;
				end
			end
			TX_STOP: if (tick) begin
				if (stop_cnt_q >= stop_len)
					tx_st_q <= TX_IDLE;
				stop_cnt_q <= stop_cnt_q + 6'h01;
			end
			default: tx_st_q <= TX_IDLE;
			endcase
		end
	end
	wire transmitter_idle_flag = (tx_st_q == TX_IDLE) & tx_holding_empty_flag_q;
	assign serial_output_pin = tx_line_q & ~fmt_q[`FMT_BREAK];

	// Receive input synchroniser
	reg rx_s1_q, rx_s2_q;
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_in;
			rx_s2_q <= rx_s1_q;
		end
	end

	// Receiver; samples mid-bit
	localparam RX_IDLE = 4'b0001, RX_START = 4'b0010;
	localparam RX_DATA = 4'b0100, RX_STOP  = 4'b1000;
	reg [3:0] rx_st_q, rx_cnt_q, rx_sub_q;
	reg [7:0] rx_sh_q;
	reg       rx_pdone_q, rx_par_q, rx_allz_q, rx_wait_q;
	reg       rx_done, rx_fe, rx_pe, rx_bi;
	wire      rx_mid = tick & (rx_sub_q == `TICK_MAX);
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 4'h0;
			rx_sub_q <= 4'h0;
			rx_sh_q <= `RST_BYTE;
			rx_pdone_q <= 1'b0;
			rx_par_q <= 1'b0;
			rx_allz_q <= 1'b0;
			rx_wait_q <= 1'b0;
			rx_done <= 1'b0;
			rx_fe <= 1'b0;
			rx_pe <= 1'b0;
			rx_bi <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (tick)
				rx_sub_q <= rx_sub_q + 4'h1;
			case (rx_st_q)
			RX_IDLE: begin
				// After a break the line must return to mark
				if (rx_s2_q)
					rx_wait_q <= 1'b0;
				if (tick && !rx_s2_q && !rx_wait_q) begin
					rx_sub_q <= `RX_SUB_START;
					rx_st_q <= RX_START;
				end
			end
			RX_START: if (rx_mid) begin
				rx_cnt_q <= 4'h0;
				rx_pdone_q <= 1'b0;
				rx_allz_q <= 1'b1;
				rx_sh_q <= `RST_BYTE;
				rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA; // Glitch reject
			end
			RX_DATA: if (rx_mid) begin
				rx_allz_q <= rx_allz_q & ~rx_s2_q;
				if (rx_cnt_q < nbits) begin
					rx_sh_q[rx_cnt_q[2:0]] <= rx_s2_q;
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q + 4'h1 == nbits && !fmt_q[`FMT_PAR_EN])
						rx_st_q <= RX_STOP;
				end else begin
					rx_par_q <= rx_s2_q;
					rx_st_q <= RX_STOP;
				end
			end
			RX_STOP: if (rx_mid) begin
				rx_fe <= ~rx_s2_q;
				rx_bi <= rx_allz_q & ~rx_s2_q;
				rx_pe <= fmt_q[`FMT_PAR_EN] &
					(rx_par_q != par_of(rx_sh_q, nbits, fmt_q));
				rx_done <= 1'b1;
				rx_wait_q <= rx_allz_q & ~rx_s2_q;
				// Framing error: treat the low as the next start
				rx_st_q <= RX_IDLE;
			end
			default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Register writes and status flags; a set beats a read clear
	wire rd_link = rd & (addr == `OFS_LINK);
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fmt_q <= `RST_BYTE;
			ier_q <= `RST_BYTE;
			hso_q <= `RST_HSO;
			scr_q <= `RST_BYTE;
			tcr_q <= `RST_BYTE;
			div_lo_q <= `RST_DIV_LO;
			div_hi_q <= `RST_BYTE;
			thr_q <= `RST_BYTE;
			rbr_q <= `RST_BYTE;
			tx_holding_empty_flag_q <= 1'b1;
			{dr_q, oe_q, pe_q, fe_q, bi_q} <= 5'h00;
		end else begin
			if (wr) begin
				case (addr)
				`OFS_DATA: if (dsel) div_lo_q <= wdata;
					else thr_q <= wdata;
				`OFS_IER: if (dsel) div_hi_q <= wdata;
					else ier_q <= {4'h0, wdata[3:0]};
				`OFS_IIR:     tcr_q <= wdata & 8'h10;
				`OFS_FMT:     fmt_q <= wdata;
				`OFS_HSO:     hso_q <= {3'h0, wdata[4:0]};
				`OFS_SCRATCH: if (ext_mode) scr_q <= wdata;
				default: ;
				endcase
			end
			if (wr && addr == `OFS_DATA && !dsel)
				tx_holding_empty_flag_q <= 1'b0;
			else if (tx_st_q == TX_IDLE && !tx_holding_empty_flag_q && tick)
				tx_holding_empty_flag_q <= 1'b1;
			if (rx_done) begin
				rbr_q <= rx_sh_q;
				dr_q <= 1'b1;
			end else if (rd && addr == `OFS_DATA && !dsel)
				dr_q <= 1'b0;
			oe_q <= (rx_done & dr_q) | (oe_q & ~rd_link);
			pe_q <= (rx_done & rx_pe) | (pe_q & ~rd_link);
			fe_q <= (rx_done & rx_fe) | (fe_q & ~rd_link);
			bi_q <= (rx_done & rx_bi) | (bi_q & ~rd_link);
		end
	end

	// Read mux
	// status readable anytime
	always @* begin
		case (addr)
		`OFS_DATA:    rdata = dsel ? div_lo_q : rbr_q;
		`OFS_IER:     rdata = dsel ? div_hi_q : ier_q;
		`OFS_IIR:     rdata = `RST_IIR;
		`OFS_FMT:     rdata = fmt_q;
		`OFS_HSO:     rdata = hso_q;
		`OFS_LINK:    rdata = {1'b0, ext_mode ? transmitter_idle_flag : (tx_st_q == TX_IDLE),
			tx_holding_empty_flag_q, bi_q, fe_q, pe_q, oe_q, dr_q};
		`OFS_HSI:     rdata = `RST_BYTE;
		`OFS_SCRATCH: rdata = ext_mode ? scr_q : `RST_BYTE;
		default:      rdata = `RST_BYTE;
		endcase
	end
endmodule // serial_channel

// *** design/dual_serial_unit.v ***
// Top of the dual serial unit: two channels behind one host byte bus
`include "dual_uart_defines.vh"
module dual_serial_unit (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       compat_mode_select_pin,
	input  wire       channel_select_line,
	input  wire [2:0] addr,
	input  wire       rd_stb,
	input  wire       wr_stb,
	input  wire [7:0] wdata,
	output reg  [7:0] rdata,
	input  wire       serial_in_a,
	input  wire       serial_in_b,
	output wire       serial_output_pin_a,
	output wire       serial_output_pin_b
);
	reg        mode_s1_q, mode_s2_q, ext_mode_q;
	reg  [2:0] arm_q;
	wire [7:0] rdata_a, rdata_b;

	// latch mode at release
	// Pin is synchronised first, so the mode settles on the third edge
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mode_s1_q  <= 1'b0;
			mode_s2_q  <= 1'b0;
			ext_mode_q <= 1'b0;
			arm_q      <= `MODE_ARM;
		end else begin
			mode_s1_q <= compat_mode_select_pin;
			mode_s2_q <= mode_s1_q;
			arm_q     <= {arm_q[1:0], 1'b0};
			if (arm_q[2])
				ext_mode_q <= mode_s2_q; // Frozen after arming
		end
	end

	serial_channel u_chan_a (
		.core_clk          (core_clk),
		.reset             (reset),
		.ext_mode          (ext_mode_q),
		.sel               (channel_select_line),
		.addr              (addr),
		.rd_stb            (rd_stb),
		.wr_stb            (wr_stb),
		.wdata             (wdata),
		.rdata             (rdata_a),
		.serial_in         (serial_in_a),
		.serial_output_pin (serial_output_pin_a)
	);
	serial_channel u_chan_b (
		.core_clk          (core_clk),
		.reset             (reset),
		.ext_mode          (ext_mode_q),
		.sel               (~channel_select_line),
		.addr              (addr),
		.rd_stb            (rd_stb),
		.wr_stb            (wr_stb),
		.wdata             (wdata),
		.rdata             (rdata_b),
		.serial_in         (serial_in_b),
		.serial_output_pin (serial_output_pin_b)
	);

	// Registered read data, valid the cycle after the strobe
	always @(posedge core_clk or posedge reset) begin
		if (reset)
			rdata <= `RST_BYTE;
		else
			rdata <= channel_select_line ? rdata_a : rdata_b;
	end
endmodule // dual_serial_unit

// *** verification/serial_peer_model.sv ***
// Far-side serial peer: captures and sends framed characters
module serial_peer_model #(
	parameter int BIT = 32
) (
	input  logic core_clk,
	input  logic line_a,
	input  logic line_b,
	output logic to_a,
	output logic to_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines idle at mark until a frame is sent
	initial begin
		to_a = 1'b1;
		to_b = 1'b1;
	end
	// Mid-bit sampling; bounded wait for the start edge
	task automatic catch_frame(input logic ch, input int n,
		output logic [11:0] f);
		int i;
		f = 12'hFFF;
		i = 0;
		while ((ch ? line_a : line_b) !== 1'b0 && i < 4000) begin
			@(posedge core_clk);
			i++;
		end
		repeat (BIT / 2) @(posedge core_clk);
		for (i = 0; i < n; i++) begin
			f[i] = ch ? line_a : line_b;
			repeat (BIT) @(posedge core_clk);
		end
	endtask
	task automatic send(input logic ch, input int n, input logic [11:0] f);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			if (ch)
				to_a <= f[i];
			else
				to_b <= f[i];
			repeat (BIT - 1) @(posedge core_clk);
		end
	endtask
endmodule // serial_peer_model

// *** verification/dual_serial_unit_checker.sv ***
// Port-level assertions for the dual serial unit
module dual_serial_unit_checker (
	input logic       core_clk,
	input logic       reset,
	input logic       compat_mode_select_pin,
	input logic       channel_select_line,
	input logic [2:0] addr,
	input logic       rd_stb,
	input logic       wr_stb,
	input logic [7:0] wdata,
	input logic [7:0] rdata,
	input logic       serial_in_a,
	input logic       serial_in_b,
	input logic       serial_output_pin_a,
	input logic       serial_output_pin_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] fmt_q [2];
	logic [7:0] scr_q [2];
	logic       ext_q;
	logic [1:0] arm_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// Shadow copies; mode caught at third edge after release
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			fmt_q[0] <= 8'h00;
			fmt_q[1] <= 8'h00;
			scr_q[0] <= 8'h00;
			scr_q[1] <= 8'h00;
			ext_q <= 1'b0;
			arm_q <= 2'h0;
		end else begin
			if (arm_q != 2'h3)
				arm_q <= arm_q + 2'h1;
			if (arm_q == 2'h2)
				ext_q <= compat_mode_select_pin;
			if (wr_stb && addr == 3'h3)
				fmt_q[channel_select_line] <= wdata;
			if (wr_stb && addr == 3'h7 && ext_q)
				scr_q[channel_select_line] <= wdata;
		end
	end
	sequence s_rd(logic [2:0] o);
		rd_stb && addr == o;
	endsequence
	a_reset_mark: assert property ($fell(reset) |->
		serial_output_pin_a && serial_output_pin_b)
		else $error("pins not marking");
	a_break_hold: assert property (fmt_q[1][6] [*3] |->
		!serial_output_pin_a) else $error("break not low");
	a_fmt_readback: assert property (s_rd(3'h3) |=>
		rdata == $past(fmt_q[channel_select_line]))
		else $error("format readback");
	a_ident_value: assert property (s_rd(3'h2) |=>
		rdata == 8'h01) else $error("ident value");
	a_hsi_zero: assert property (s_rd(3'h6) |=>
		rdata == 8'h00) else $error("input flags");
	a_scratch_gone: assert property (s_rd(3'h7) ##0 !ext_q |=>
		rdata == 8'h00) else $error("legacy scratch");
	a_scratch_kept: assert property (s_rd(3'h7) ##0 ext_q |=>
		rdata == $past(scr_q[channel_select_line]))
		else $error("scratch readback");
	a_status_top: assert property (s_rd(3'h5) |=>
		!rdata[7]) else $error("status bit 7");
endmodule // dual_serial_unit_checker
bind dual_serial_unit dual_serial_unit_checker u_chk (
	.core_clk(core_clk), .reset(reset), .addr(addr),
	.compat_mode_select_pin(compat_mode_select_pin),
	.channel_select_line(channel_select_line),
	.rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata),
	.serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
	.serial_output_pin_a(serial_output_pin_a),
	.serial_output_pin_b(serial_output_pin_b));

// *** verification/tb_dual_serial_unit.sv ***
// Self-checking bench for the dual serial unit
module tb_dual_serial_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        compat_mode_select_pin = 1'b1;
	logic        channel_select_line = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic        rd_stb = 1'b0;
	logic        wr_stb = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata;
	logic        serial_in_a;
	logic        serial_in_b;
	logic        serial_output_pin_a;
	logic        serial_output_pin_b;
	int          errors = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [7:0]  v;
	logic [11:0] got;
	logic [7:0]  fmts [8] = '{8'h00, 8'h05, 8'h0A, 8'h0F,
		8'h1B, 8'h2C, 8'h3D, 8'h1A};
	always #5 core_clk = ~core_clk;
	dual_serial_unit u_dual_serial_unit (
		.core_clk(core_clk), .reset(reset), .addr(addr),
		.compat_mode_select_pin(compat_mode_select_pin),
		.channel_select_line(channel_select_line),
		.rd_stb(rd_stb), .wr_stb(wr_stb), .wdata(wdata), .rdata(rdata),
		.serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
		.serial_output_pin_a(serial_output_pin_a),
		.serial_output_pin_b(serial_output_pin_b));
	serial_peer_model #(.BIT(32)) u_serial_peer_model (
		.core_clk(core_clk), .line_a(serial_output_pin_a),
		.line_b(serial_output_pin_b), .to_a(serial_in_a),
		.to_b(serial_in_b));
	// Hang guard, about six times the expected run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string s, input logic [11:0] e,
		input logic [11:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic ch, input logic [2:0] a,
		input logic [7:0] d);
		@(posedge core_clk);
		channel_select_line <= ch;
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	// Read data settles one edge after the strobe
	task automatic rd(input logic ch, input logic [2:0] a,
		output logic [7:0] d);
		@(posedge core_clk);
		channel_select_line <= ch;
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask
	// Expected line bits, start first; n counts sampled bits
	function automatic logic [11:0] frame(input logic [7:0] d,
		input logic [7:0] f, output int n);
		int len;
		logic [7:0] m;
		len = 5 + f[1:0];
		m = d & (8'hFF >> (8 - len));
		frame = 12'hFFF;
		frame[0] = 1'b0;
		for (int i = 0; i < len; i++)
			frame[1 + i] = d[i];
		n = 1 + len;
		if (f[3]) begin
			frame[n] = f[5] ? ~f[4] : ^m ^ ~f[4];
			n++;
		end
		n = n + ((f[2] && len > 5) ? 2 : 1);
	endfunction
	// Poll the link flags until the transmitter has gone idle
	task automatic wait_idle(input logic ch);
		v = 8'h00;
		for (int k = 0; k < 400 && !v[6]; k++)
			rd(ch, 3'h5, v);
	endtask
	task automatic reset_unit(input logic ext);
		@(posedge core_clk);
		compat_mode_select_pin <= ext;
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic t_reset();
		chk("pin a", 12'h001, serial_output_pin_a);
		chk("pin b", 12'h001, serial_output_pin_b);
		rd(1'b0, 3'h5, v);
		chk("flags b", 12'h060, v);
		rd(1'b1, 3'h3, v);
		chk("format a", 12'h000, v);
		rd(1'b1, 3'h2, v);
		chk("ident a", 12'h001, v);
		rd(1'b1, 3'h6, v);
		chk("inputs a", 12'h000, v);
	endtask
	// All lengths, stop counts and parity kinds on channel A
	task automatic t_frames();
		int n;
		logic [11:0] e;
		logic [7:0] d;
		d = 8'h96;
		wr(1'b1, 3'h3, 8'h80);
		wr(1'b1, 3'h0, 8'h02);
		wr(1'b1, 3'h1, 8'h00);
		rd(1'b1, 3'h0, v);
		chk("divisor a", 12'h002, v);
		for (int i = 0; i < 8; i++) begin
			wr(1'b1, 3'h3, fmts[i]);
			d = d + 8'h3B;
			e = frame(d, fmts[i], n);
			// Second character queued: a short stop shows as a low
			fork
				u_serial_peer_model.catch_frame(1'b1, n, got);
				begin
					wr(1'b1, 3'h0, d);
					wr(1'b1, 3'h0, 8'h00);
				end
			join
			chk("frame a", e, got);
			wait_idle(1'b1);
			chk("idle a", 12'h001, v[6]);
		end
	endtask
	// Channel B receive: good parity, then a parity fault
	task automatic t_receive();
		int n;
		logic [11:0] f;
		wr(1'b0, 3'h3, 8'h80);
		wr(1'b0, 3'h0, 8'h02);
		wr(1'b0, 3'h3, 8'h1B);
		f = frame(8'hC3, 8'h1B, n);
		u_serial_peer_model.send(1'b0, n, f);
		repeat (64) @(posedge core_clk);
		rd(1'b0, 3'h5, v);
		chk("ready b", 12'h001, v & 8'h0F);
		rd(1'b0, 3'h0, v);
		chk("data b", 12'h0C3, v);
		f[9] = ~f[9];
		u_serial_peer_model.send(1'b0, n, f);
		repeat (64) @(posedge core_clk);
		rd(1'b0, 3'h5, v);
		chk("parity b", 12'h005, v & 8'h0F);
	endtask
	// Pad character, break on holding empty, clear once idle
	task automatic t_break();
		wr(1'b1, 3'h0, 8'h00);
		v = 8'h00;
		for (int k = 0; k < 100 && !v[5]; k++)
			rd(1'b1, 3'h5, v);
		chk("empty a", 12'h001, v[5]);
		wr(1'b1, 3'h3, 8'h43);
		repeat (4) @(posedge core_clk);
		#1;
		chk("break a", 12'h000, serial_output_pin_a);
		chk("idle b", 12'h001, serial_output_pin_b);
		wait_idle(1'b1);
		chk("timer a", 12'h001, v[6]);
		chk("held a", 12'h000, serial_output_pin_a);
		wr(1'b1, 3'h3, 8'h03);
		repeat (4) @(posedge core_clk);
		#1;
		chk("release a", 12'h001, serial_output_pin_a);
	endtask
	task automatic t_scratch(input logic ext);
		wr(1'b1, 3'h7, 8'h5A);
		rd(1'b1, 3'h7, v);
		chk("scratch a", ext ? 12'h05A : 12'h000, v);
		rd(1'b0, 3'h7, v);
		chk("scratch b", 12'h000, v);
	endtask
	initial begin
		reset_unit(1'b1);
		t_reset();
		t_frames();
		t_receive();
		t_break();
		t_scratch(1'b1);
		reset_unit(1'b0);
		t_scratch(1'b0);
		complete_run();
	end
endmodule // tb_dual_serial_unit
